//--- design/cidbl_alu.sv
// literal arithmetic and logic against the working register
`timescale 1ns/100ps
module cidbl_alu
    import cidbl_pkg::*;
(
    // operands
    input cidbl_op_e i_op,
    input wire logic [7:0] i_w,
    input wire logic [7:0] i_k,
    input wire logic [4:0] i_status,
    // result
    output logic [7:0] o_res,
    output logic [4:0] o_status
);
    logic [8:0] sum;
    logic [4:0] nib;
    logic [7:0] b_op;
    logic is_arith;

    // subtraction is k + ~w + 1, so carry means no borrow
    always_comb begin
        is_arith = (i_op == OP_ADD_IMMEDIATE) ||
                   (i_op == OP_SUBTRACT_FROM_IMMEDIATE);
        b_op = (i_op == OP_SUBTRACT_FROM_IMMEDIATE) ? ~i_w : i_w;
        sum = {1'b0, i_k} + {1'b0, b_op} +
              {8'h00, (i_op == OP_SUBTRACT_FROM_IMMEDIATE)};
        nib = {1'b0, i_k[3:0]} + {1'b0, b_op[3:0]} +
              {4'h0, (i_op == OP_SUBTRACT_FROM_IMMEDIATE)};
        case (i_op)
            OP_AND_IMMEDIATE: o_res = i_w & i_k;
            OP_OR_IMMEDIATE: o_res = i_w | i_k;
            OP_XOR_IMMEDIATE: o_res = i_w ^ i_k;
            default: o_res = sum[7:0];
        endcase
        o_status = i_status;
        o_status[ST_Z] = (o_res == 8'h00);
        o_status[ST_N] = o_res[7];
        if (is_arith) begin
            o_status[ST_C] = sum[8];
            o_status[ST_DC] = nib[4];
            o_status[ST_OV] = (i_k[7] == b_op[7]) && (o_res[7] != i_k[7]);
        end
    end
endmodule : cidbl_alu

//--- design/cidbl_core.sv
// execution core for bit, control, literal and table instruction groups
`timescale 1ns/100ps
module cidbl_core
    import cidbl_pkg::*;
#(
    parameter int STACK_DEPTH = STK_DEPTH
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // program memory fetch
    output logic [PC_W-1:0] o_pm_addr,
    input wire logic [15:0] i_pm_instr,
    // data memory
    output logic [DA_W-1:0] o_dm_raddr,
    input wire logic [7:0] i_dm_rdata,
    output logic o_dm_we,
    output logic [DA_W-1:0] o_dm_waddr,
    output logic [7:0] o_dm_wdata,
    // port pins and timer zero
    input wire logic [7:0] i_port_pins,
    input wire logic i_t0_psa_assigned,
    output logic o_t0_prescale_clr,
    // program table access
    output logic [PC_W:0] o_tbl_addr,
    output logic o_tbl_rd,
    output logic o_tbl_we,
    output logic [7:0] o_tbl_wdata,
    input wire logic [7:0] i_tbl_rdata,
    // power management
    input wire logic i_wake,
    output logic o_wdt_clr,
    output logic o_sleeping,
    output logic o_sw_reset,
    // architectural state
    output logic [7:0] o_working_register,
    output logic [4:0] o_status,
    output logic [3:0] o_bsr,
    output logic [35:0] o_fsr,
    output logic [7:0] o_tablat,
    output logic o_timeout_status,
    output logic o_powerdown_status,
    output logic o_global_high_int_enable,
    output logic o_peripheral_low_int_enable
);
    cidbl_state_e state_reg;
    cidbl_op_e op;
    cidbl_op_e next_op;
    logic rst_int_n;
    logic [15:0] ir_reg;
    logic [PC_W-1:0] pc_reg;
    logic [PC_W:0] tblptr_reg;
    logic [7:0] pins_meta_reg, pins_sync_reg;
    logic wake_meta_reg, wake_sync_reg;
    logic run;
    logic [7:0] file_val;
    logic bit_val;
    logic cond_true;
    logic jump;
    logic flush;
    logic [PC_W-1:0] jump_tgt;
    logic [15:0] fetch_word;
    logic [3:0] bsr_next;
    logic [7:0] alu_res;
    logic [4:0] alu_status;
    logic [7:0] bit_mask;
    logic [PC_W-1:0] stk_mem [STACK_DEPTH];
    logic [SP_W-1:0] sp_reg;
    logic [PC_W-1:0] stk_top;
    logic [7:0] shadow_w_reg;
    logic [4:0] shadow_st_reg;
    logic [3:0] shadow_bsr_reg;
    logic fast_restore;

    // a reset instruction pulses this flop, which then acts like the pin
    assign rst_int_n = i_rst_n & ~o_sw_reset;
    assign run = (state_reg == ST_RUN);
    assign o_pm_addr = pc_reg;

    cidbl_decode u_decode (
        .i_instr(ir_reg),
        .o_op(op)
    );

    cidbl_decode u_decode_fetch (
        .i_instr(i_pm_instr),
        .o_op(next_op)
    );

    cidbl_alu u_alu (
        .i_op(op),
        .i_w(o_working_register),
        .i_k(ir_reg[7:0]),
        .i_status(o_status),
        .o_res(alu_res),
        .o_status(alu_status)
    );

    // pins and wake come from outside the clock domain
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pins_meta_reg <= 8'h00;
            pins_sync_reg <= 8'h00;
            wake_meta_reg <= 1'b0;
            wake_sync_reg <= 1'b0;
        end else begin
            pins_meta_reg <= i_port_pins;
            pins_sync_reg <= pins_meta_reg;
            wake_meta_reg <= i_wake;
            wake_sync_reg <= wake_meta_reg;
        end
    end

    // the pending write is forwarded so back-to-back bit ops see it, except at PORT_ADDR, which always reads the pins
    always_comb begin
        if (o_dm_raddr == PORT_ADDR) begin
            file_val = pins_sync_reg;
        end else if (o_dm_we && (o_dm_waddr == o_dm_raddr)) begin
            file_val = o_dm_wdata;
        end else begin
            file_val = i_dm_rdata;
        end
        bit_mask = 8'h01 << ir_reg[11:9];
        bit_val = |(file_val & bit_mask);
        case (ir_reg[10:8])
            3'h0: cond_true = o_status[ST_Z];
            3'h1: cond_true = !o_status[ST_Z];
            3'h2: cond_true = o_status[ST_C];
            3'h3: cond_true = !o_status[ST_C];
            3'h4: cond_true = o_status[ST_OV];
            3'h5: cond_true = !o_status[ST_OV];
            3'h6: cond_true = o_status[ST_N];
            default: cond_true = !o_status[ST_N];
        endcase
        stk_top = (sp_reg == '0) ? PC_RST : stk_mem[sp_reg - 5'h01];
        jump = 1'b0;
        flush = 1'b0;
        jump_tgt = pc_reg;
        case (op)
            OP_SKIP_IF_BIT_CLEAR: flush = !bit_val;
            OP_SKIP_IF_BIT_SET: flush = bit_val;
            OP_RELATIVE_JUMP: begin
                jump = 1'b1;
                jump_tgt = pc_reg + {{10{ir_reg[10]}}, ir_reg[10:0]};
            end
            OP_BRANCH_COND: begin
                jump = cond_true;
                jump_tgt = pc_reg + {{13{ir_reg[7]}}, ir_reg[7:0]};
            end
            OP_CALL, OP_ABSOLUTE_JUMP: begin
                jump = 1'b1;
                jump_tgt = {1'b0, i_pm_instr[11:0], ir_reg[7:0]};
            end
            OP_INTERRUPT_RETURN, OP_RETURN, OP_RETURN_WITH_LITERAL: begin
                jump = 1'b1;
                jump_tgt = stk_top;
            end
            OP_POINTER_LOAD: flush = 1'b1; // second word consumed
            default: flush = 1'b0;
        endcase
        if (!run) begin
            jump = 1'b0;
            flush = 1'b0;
        end
        // the dropped word becomes the extra no-op cycle
        fetch_word = (jump || flush) ? NOP_WORD : i_pm_instr;
        bsr_next = (run && op == OP_BANK_SELECT_LOAD) ? ir_reg[3:0] : o_bsr;
        fast_restore = ir_reg[0] &&
            (op == OP_RETURN || op == OP_INTERRUPT_RETURN);
    end

    // fetch runs one word ahead of execute
    always_ff @(posedge i_sys_clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            pc_reg <= PC_RST;
            ir_reg <= NOP_WORD;
            o_dm_raddr <= '0;
        end else if (run) begin
            pc_reg <= jump ? jump_tgt : pc_reg + 21'h000001;
            ir_reg <= fetch_word;
            if (next_op inside {OP_BIT_CLEAR, OP_BIT_SET, OP_BIT_TOGGLE,
                                OP_SKIP_IF_BIT_CLEAR, OP_SKIP_IF_BIT_SET}) begin
                if (fetch_word[8]) begin
                    o_dm_raddr <= {bsr_next, fetch_word[7:0]};
                end else if (fetch_word[7:0] < ACCESS_SPLIT) begin
                    o_dm_raddr <= {4'h0, fetch_word[7:0]};
                end else begin
                    o_dm_raddr <= {ACCESS_HI_BANK, fetch_word[7:0]};
                end
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            state_reg <= ST_RUN;
            o_sleeping <= 1'b0;
        end else begin
            case (state_reg)
                ST_RUN: begin
                    if (op == OP_SLEEP) begin
                        state_reg <= ST_ASLEEP;
                        o_sleeping <= 1'b1;
                    end else if (op == OP_PROGRAM_TABLE_READ ||
                                 op == OP_PROGRAM_TABLE_WRITE) begin
                        state_reg <= ST_TABLE;
                    end
                end
                ST_TABLE: state_reg <= ST_RUN;
                ST_ASLEEP: begin
                    if (wake_sync_reg) begin
                        state_reg <= ST_RUN;
                        o_sleeping <= 1'b0;
                    end
                end
                default: state_reg <= ST_RUN;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            o_working_register <= W_RST;
            o_status <= STATUS_RST;
            o_bsr <= BSR_RST;
        end else if (run) begin
            o_bsr <= bsr_next;
            case (op)
                OP_ADD_IMMEDIATE, OP_SUBTRACT_FROM_IMMEDIATE, OP_AND_IMMEDIATE,
                OP_OR_IMMEDIATE, OP_XOR_IMMEDIATE: begin
                    o_working_register <= alu_res;
                    o_status <= alu_status;
                end
                OP_MOVE_IMMEDIATE: o_working_register <= ir_reg[7:0];
                OP_RETURN_WITH_LITERAL: o_working_register <= ir_reg[7:0];
                default: begin
                    if (fast_restore) begin
                        o_working_register <= shadow_w_reg;
                        o_status <= shadow_st_reg;
                        o_bsr <= shadow_bsr_reg;
                    end
                end
            endcase
        end
    end

    // fast context shadow, saved by a call whose select bit is set
    always_ff @(posedge i_sys_clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            shadow_w_reg <= W_RST;
            shadow_st_reg <= STATUS_RST;
            shadow_bsr_reg <= BSR_RST;
        end else if (run && op == OP_CALL && ir_reg[8]) begin
            shadow_w_reg <= o_working_register;
            shadow_st_reg <= o_status;
            shadow_bsr_reg <= o_bsr;
        end
    end

    // the stack saturates at both ends rather than wrapping
    always_ff @(posedge i_sys_clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            sp_reg <= '0;
        end else if (run && op == OP_CALL) begin
            if (sp_reg < SP_W'(STACK_DEPTH)) begin
                sp_reg <= sp_reg + 5'h01;
            end
        end else if (run && jump && op != OP_BRANCH_COND &&
                     op != OP_RELATIVE_JUMP && op != OP_ABSOLUTE_JUMP) begin
            if (sp_reg != '0) begin
                sp_reg <= sp_reg - 5'h01;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (run && op == OP_CALL && sp_reg < SP_W'(STACK_DEPTH)) begin
            stk_mem[sp_reg] <= pc_reg + 21'h000001;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_fsr
            always_ff @(posedge i_sys_clk or negedge rst_int_n) begin
                if (!rst_int_n) begin
                    o_fsr[gi*12 +: 12] <= FSR_RST;
                end else if (run && op == OP_POINTER_LOAD &&
                             ir_reg[5:4] == 2'(gi)) begin
                    o_fsr[gi*12 +: 12] <= {ir_reg[3:0], i_pm_instr[7:0]};
                end
            end
        end
    endgenerate

    always_ff @(posedge i_sys_clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            o_dm_we <= 1'b0;
            o_dm_waddr <= '0;
            o_dm_wdata <= 8'h00;
            o_t0_prescale_clr <= 1'b0;
        end else begin
            o_dm_we <= 1'b0;
            o_t0_prescale_clr <= 1'b0;
            if (run && op inside {OP_BIT_CLEAR, OP_BIT_SET, OP_BIT_TOGGLE}) begin
                o_dm_we <= 1'b1;
                o_dm_waddr <= o_dm_raddr;
                case (op)
                    OP_BIT_CLEAR: o_dm_wdata <= file_val & ~bit_mask;
                    OP_BIT_SET: o_dm_wdata <= file_val | bit_mask;
                    default: o_dm_wdata <= file_val ^ bit_mask;
                endcase
                o_t0_prescale_clr <= (o_dm_raddr == TIMER_ZERO_COUNT_ADDR) &&
                                     i_t0_psa_assigned;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            tblptr_reg <= '0;
            o_tbl_addr <= '0;
            o_tbl_rd <= 1'b0;
            o_tbl_we <= 1'b0;
            o_tbl_wdata <= 8'h00;
            o_tablat <= 8'h00;
        end else begin
            o_tbl_rd <= 1'b0;
            o_tbl_we <= 1'b0;
            if (o_tbl_rd) begin
                o_tablat <= i_tbl_rdata;
            end
            if (run && (op == OP_PROGRAM_TABLE_READ ||
                        op == OP_PROGRAM_TABLE_WRITE)) begin
                o_tbl_rd <= (op == OP_PROGRAM_TABLE_READ);
                o_tbl_we <= (op == OP_PROGRAM_TABLE_WRITE);
                o_tbl_wdata <= o_tablat;
                case (ir_reg[1:0])
                    TBL_POSTINC: begin
                        o_tbl_addr <= tblptr_reg;
                        tblptr_reg <= tblptr_reg + 22'h000001;
                    end
                    TBL_POSTDEC: begin
                        o_tbl_addr <= tblptr_reg;
                        tblptr_reg <= tblptr_reg - 22'h000001;
                    end
                    TBL_PREINC: begin
                        o_tbl_addr <= tblptr_reg + 22'h000001;
                        tblptr_reg <= tblptr_reg + 22'h000001;
                    end
                    default: o_tbl_addr <= tblptr_reg;
                endcase
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            o_wdt_clr <= 1'b0;
            o_timeout_status <= TO_RST;
            o_powerdown_status <= PD_RST;
            o_global_high_int_enable <= 1'b0;
            o_peripheral_low_int_enable <= 1'b0;
        end else begin
            o_wdt_clr <= run && (op == OP_WATCHDOG_KICK || op == OP_SLEEP);
            if (run && op == OP_WATCHDOG_KICK) begin
                o_timeout_status <= 1'b1;
                o_powerdown_status <= 1'b1;
            end
            if (run && op == OP_SLEEP) begin
                o_timeout_status <= 1'b1;
                o_powerdown_status <= 1'b0;
            end
            if (run && op == OP_INTERRUPT_RETURN) begin
                o_global_high_int_enable <= 1'b1;
                o_peripheral_low_int_enable <= 1'b1;
            end
        end
    end

    // only the pin clears this flop, so the pulse lasts exactly one cycle
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_sw_reset <= 1'b0;
        end else begin
            o_sw_reset <= run && (op == OP_SOFT_RESET) &&
                          !o_sw_reset;
        end
    end
endmodule : cidbl_core

//--- design/cidbl_decode.sv
// opcode decoder: one 16-bit word to an operation code
`timescale 1ns/100ps
module cidbl_decode
    import cidbl_pkg::*;
(
    // instruction word
    input wire logic [15:0] i_instr,
    // decoded operation
    output cidbl_op_e o_op
);
    always_comb begin
        o_op = OP_NOP;
        case (i_instr[15:12])
            4'h9: o_op = OP_BIT_CLEAR;
            4'h8: o_op = OP_BIT_SET;
            4'h7: o_op = OP_BIT_TOGGLE;
            4'hB: o_op = OP_SKIP_IF_BIT_CLEAR;
            4'hA: o_op = OP_SKIP_IF_BIT_SET;
            4'hD: begin
                if (!i_instr[11]) begin
                    o_op = OP_RELATIVE_JUMP;
                end
            end
            4'hE: begin
                if (!i_instr[11]) begin
                    o_op = OP_BRANCH_COND;
                end else if (i_instr[10:9] == 2'h2) begin
                    o_op = OP_CALL;
                end else if (i_instr[10:8] == 3'h7) begin
                    o_op = OP_ABSOLUTE_JUMP;
                end else if (i_instr[10:6] == 5'h18) begin
                    o_op = OP_POINTER_LOAD;
                end
            end
            4'hF: o_op = OP_NOP; // lone second word runs as a no-op
            4'h0: begin
                case (i_instr[11:8])
                    4'hF: o_op = OP_ADD_IMMEDIATE;
                    4'hB: o_op = OP_AND_IMMEDIATE;
                    4'h9: o_op = OP_OR_IMMEDIATE;
                    4'hA: o_op = OP_XOR_IMMEDIATE;
                    4'h8: o_op = OP_SUBTRACT_FROM_IMMEDIATE;
                    4'hE: o_op = OP_MOVE_IMMEDIATE;
                    4'hC: o_op = OP_RETURN_WITH_LITERAL;
                    4'h1: begin
                        if (i_instr[7:4] == 4'h0) begin
                            o_op = OP_BANK_SELECT_LOAD;
                        end
                    end
                    4'h0: begin
                        if (i_instr[7:0] == 8'hFF) begin
                            o_op = OP_SOFT_RESET;
                        end else if (i_instr[7:1] == 7'h08) begin
                            o_op = OP_INTERRUPT_RETURN;
                        end else if (i_instr[7:1] == 7'h09) begin
                            o_op = OP_RETURN;
                        end else if (i_instr[7:0] == 8'h04) begin
                            o_op = OP_WATCHDOG_KICK;
                        end else if (i_instr[7:0] == 8'h03) begin
                            o_op = OP_SLEEP;
                        end else if (i_instr[7:2] == 6'h02) begin
                            o_op = OP_PROGRAM_TABLE_READ;
                        end else if (i_instr[7:2] == 6'h03) begin
                            o_op = OP_PROGRAM_TABLE_WRITE;
                        end
                    end
                    default: o_op = OP_NOP;
                endcase
            end
            default: o_op = OP_NOP;
        endcase
    end
endmodule : cidbl_decode

//--- design/cidbl_pkg.sv
// shared constants, opcode enumeration and reset values of the decoder core
package cidbl_pkg;
    localparam int PC_W = 21;
    localparam int DA_W = 12;
    localparam int STK_DEPTH = 31;
    localparam int SP_W = 5;
    // data memory map points
    localparam logic [11:0] PORT_ADDR = 12'hF81;
    localparam logic [11:0] TIMER_ZERO_COUNT_ADDR = 12'hFD6;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
    // status register bit positions
    localparam int ST_C = 0;
    localparam int ST_DC = 1;
    localparam int ST_Z = 2;
    localparam int ST_OV = 3;
    localparam int ST_N = 4;
    // values after reset
    localparam logic [PC_W-1:0] PC_RST = 21'h000000;
    localparam logic [15:0] NOP_WORD = 16'h0000;
    localparam logic [7:0] W_RST = 8'h00;
    localparam logic [4:0] STATUS_RST = 5'h00;
    localparam logic [3:0] BSR_RST = 4'h0;
    localparam logic [11:0] FSR_RST = 12'h000;
    localparam logic TO_RST = 1'b1;
    localparam logic PD_RST = 1'b1;
    // table pointer modes held in the low two opcode bits
    localparam logic [1:0] TBL_PLAIN = 2'h0;
    localparam logic [1:0] TBL_POSTINC = 2'h1;
    localparam logic [1:0] TBL_POSTDEC = 2'h2;
    localparam logic [1:0] TBL_PREINC = 2'h3;

    typedef enum logic [4:0] {
        OP_NOP = 5'h00,
        OP_BIT_CLEAR = 5'h01,
        OP_BIT_SET = 5'h02,
        OP_BIT_TOGGLE = 5'h03,
        OP_SKIP_IF_BIT_CLEAR = 5'h04,
        OP_SKIP_IF_BIT_SET = 5'h05,
        OP_RELATIVE_JUMP = 5'h06,
        OP_BRANCH_COND = 5'h07,
        OP_CALL = 5'h08,
        OP_ABSOLUTE_JUMP = 5'h09,
        OP_WATCHDOG_KICK = 5'h0A,
        OP_SLEEP = 5'h0B,
        OP_SOFT_RESET = 5'h0C,
        OP_INTERRUPT_RETURN = 5'h0D,
        OP_RETURN = 5'h0E,
        OP_RETURN_WITH_LITERAL = 5'h0F,
        OP_ADD_IMMEDIATE = 5'h10,
        OP_AND_IMMEDIATE = 5'h11,
        OP_OR_IMMEDIATE = 5'h12,
        OP_XOR_IMMEDIATE = 5'h13,
        OP_SUBTRACT_FROM_IMMEDIATE = 5'h14,
        OP_MOVE_IMMEDIATE = 5'h15,
        OP_BANK_SELECT_LOAD = 5'h16,
        OP_POINTER_LOAD = 5'h17,
        OP_PROGRAM_TABLE_READ = 5'h18,
        OP_PROGRAM_TABLE_WRITE = 5'h19
    } cidbl_op_e;

    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_TABLE = 2'b01,
        ST_ASLEEP = 2'b10
    } cidbl_state_e;
endpackage : cidbl_pkg

//--- test/cidbl_chk.sv
// port assertions for the decoder core
`timescale 1ns/100ps
module cidbl_chk
    import cidbl_pkg::*;
(
    // watched ports
    input logic i_sys_clk, i_rst_n, o_dm_we, o_t0_prescale_clr, o_tbl_rd,
    input logic o_tbl_we, o_wdt_clr, o_sleeping, o_sw_reset,
    input logic o_timeout_status, o_powerdown_status,
    input logic [PC_W-1:0] o_pm_addr,
    input logic [DA_W-1:0] o_dm_waddr
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    AST_SWR_PC: assert property (o_sw_reset |-> ##[0:1]
        o_pm_addr == PC_RST) else $error("pc not cleared by soft reset");
    AST_SWR_ONE: assert property (o_sw_reset |=> !o_sw_reset)
        else $error("soft reset pulse too long");
    AST_NAP_HOLD: assert property (o_sleeping && $past(o_sleeping)
        |-> $stable(o_pm_addr)) else $error("fetch moved while asleep");
    AST_NAP_PD: assert property ($rose(o_sleeping) |-> ##[0:1]
        (o_timeout_status && !o_powerdown_status)) else $error("sleep bits");
    AST_KICK_TO: assert property (o_wdt_clr |-> ##[0:1]
        o_timeout_status) else $error("timeout bit not set");
    AST_TBL_STALL: assert property (o_tbl_rd |-> ##[0:1]
        $stable(o_pm_addr)) else $error("no fetch stall on table read");
    AST_TBL_EXCL: assert property (o_tbl_rd |-> !o_tbl_we)
        else $error("table read and write together");
    AST_PRESCALE: assert property (o_t0_prescale_clr |-> o_dm_we &&
        o_dm_waddr == TIMER_ZERO_COUNT_ADDR) else $error("stray prescaler clear");
endmodule : cidbl_chk
bind cidbl_core cidbl_chk u_chk (.*);

//--- test/cpu_instr_decode_bit_ctrl_lit_test.sv
// self-checking bench for the decoder core
`timescale 1ns/100ps
module cpu_instr_decode_bit_ctrl_lit_test;
    import cidbl_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, wake = 1'b0, swr, slp, to, pd, gie, pie;
    logic [7:0] w, tl;
    logic [4:0] st;
    logic [3:0] bank_select_register;
    logic [35:0] file_select_pointer;
    logic [PC_W-1:0] pa;
    logic psa = 1'b1, pclr, twe, wclr;
    logic [7:0] pins = 8'h00, dwd, twd;
    logic [DA_W-1:0] dra, dwa;
    logic [PC_W:0] ta;
    int n_pclr = 0, n_twe = 0, n_wclr = 0;
    logic [15:0] pm [0:63];
    int bad_count = 0, n_compared = 0;
    cidbl_core DUT (.i_sys_clk(clk), .i_rst_n(rst_n), .o_pm_addr(pa),
        .i_pm_instr(pm[pa[5:0]]), .o_dm_raddr(dra), .i_dm_rdata(8'h01),
        .o_dm_we(), .o_dm_waddr(dwa), .o_dm_wdata(dwd), .i_port_pins(pins),
        .i_t0_psa_assigned(psa), .o_t0_prescale_clr(pclr), .o_tbl_addr(ta),
        .o_tbl_rd(), .o_tbl_we(twe), .o_tbl_wdata(twd), .i_tbl_rdata(8'h5A),
        .i_wake(wake), .o_wdt_clr(wclr), .o_sleeping(slp), .o_sw_reset(swr),
        .o_working_register(w), .o_status(st), .o_bsr(bank_select_register), .o_fsr(file_select_pointer),
        .o_tablat(tl), .o_timeout_status(to), .o_powerdown_status(pd),
        .o_global_high_int_enable(gie), .o_peripheral_low_int_enable(pie));
    initial forever #4 clk = ~clk;
    // pulses stand one cycle, so each is seen at exactly one falling edge
    always @(negedge clk) begin
        if (pclr === 1'b1)
            n_pclr++;
        if (twe === 1'b1)
            n_twe++;
        if (wclr === 1'b1)
            n_wclr++;
    end
    initial begin
        #20us bad_count++;
        results;
    end
    task automatic chk(input logic [35:0] g, e);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    // each program restarts from a pin reset so no state leaks across
    task automatic run(input int n);
        rst_n = 1'b0;
        repeat (6) @(negedge clk);
        n_pclr = 0;
        n_twe = 0;
        n_wclr = 0;
        rst_n = 1'b1;
        repeat (n) @(negedge clk);
    endtask : run
    task automatic t_lit;
        pm = '{0: 16'h0F7F, 1: 16'h0F01, 2: 16'h0B0F, 3: 16'h0805,
            4: 16'h0105, 5: 16'h0A05, 6: 16'h0990, default: 16'h0000};
        run(12);
        chk({w, st}, {8'h90, 5'h13});
        chk(bank_select_register, 4'h5);
    endtask : t_lit
    // only the jump traps at 3 and 11 spoil the result; skipped literals and the untaken branch do not
    task automatic t_flow;
        pm = '{0: 16'hEF08, 1: 16'hF000, 2: 16'h0E11, 3: 16'hEF3F,
            8: 16'hEE1A, 9: 16'hF0BC, 10: 16'hA000, 11: 16'hEF20,
            12: 16'hF000, 13: 16'h0E55, 14: 16'hE101, 15: 16'h0E11,
            16: 16'hE001, 17: 16'hD001, 18: 16'h0E44, 19: 16'hEC28,
            20: 16'hF000, 21: 16'hEC30, 22: 16'hF000, 23: 16'h0F01,
            24: 16'hD7FF, 40: 16'h0C66, 48: 16'h0010, default: 16'h0000};
        // the self-loop at 24 parks the core before the return at 40 recurs
        run(50);
        chk(w, 8'h67);
        chk({gie, pie}, 2'b11);
        chk(w, 8'h67);
        chk(file_select_pointer, 36'h000ABC000);
    endtask : t_flow
    // a port toggle must read the pins, not the data memory value
    task automatic t_port;
        pins = 8'hA5;
        psa = 1'b0;
        pm = '{2: 16'h90D6, 3: 16'h7081, 4: 16'h0009, 5: 16'h000F,
            6: 16'hB200, 7: 16'h0E77, 8: 16'hD7FF, default: 16'h0000};
        run(14);
        chk({dra, dwa, dwd}, {12'h000, 12'hF81, 8'hA4});
        chk(ta, 22'h000002);
        chk({w, twd}, 16'h005A);
        chk({n_twe[3:0], n_pclr[3:0]}, 8'h10);
    endtask : t_port
    task automatic t_pwr;
        psa = 1'b1;
        pm = '{0: 16'h0003, 1: 16'h0004, 2: 16'h80D6, 3: 16'h0008,
            20: 16'h00FF, default: 16'h0000};
        run(8);
        chk({slp, to, pd}, 3'b110);
        wake = 1'b1;
        repeat (12) @(negedge clk);
        chk({slp, pd, tl}, {2'b01, 8'h5A});
        chk({n_wclr[3:0], n_pclr[3:0]}, 8'h21);
        for (int i = 0; i < 24 && swr !== 1'b1; i++) @(negedge clk);
        chk(swr, 1'b1);
    endtask : t_pwr
    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : results
    initial begin
        t_lit;
        t_flow;
        t_port;
        t_pwr;
        results;
    end
endmodule : cpu_instr_decode_bit_ctrl_lit_test
